// *** bfs_defs.svh ***
// Timing constants for the buck fault supervisor
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH
`define BFS_CLK_MHZ       250
`define BFS_UV_DELAY_US   1000
`define BFS_UV_ARM_US     1200
`define BFS_MASK_HOLD_US  900
`define BFS_PG_RISE_US    1000
`define BFS_PG_FALL_US    2
`define BFS_UV_DELAY_CYC  (`BFS_UV_DELAY_US * `BFS_CLK_MHZ)
`define BFS_UV_ARM_CYC    (`BFS_UV_ARM_US * `BFS_CLK_MHZ)
`define BFS_MASK_HOLD_CYC (`BFS_MASK_HOLD_US * `BFS_CLK_MHZ)
`define BFS_PG_RISE_CYC   (`BFS_PG_RISE_US * `BFS_CLK_MHZ)
`define BFS_PG_FALL_CYC   (`BFS_PG_FALL_US * `BFS_CLK_MHZ)
`define BFS_CNT_W         20
`define BFS_DRV_RESET     3'h1
`endif

// *** bfs_pkg.sv ***
// Types shared by the buck fault supervisor
package bfs_pkg;
   // Comparator results from the analog front end
   typedef struct packed {
      logic over_120;    // Feedback above 120 percent
      logic under_70;    // Feedback below 70 percent
      logic in_pg_rise;  // Within +10/-5 percent
      logic out_pg_fall; // Outside +15/-10 percent
      logic bias_uvlo;   // Bias supply below lockout
      logic over_temp;   // Die above thermal limit
      logic tran_out;    // Transition pin outside window
   } bfs_cmp_t;
   // Gate driver and discharge controls
   typedef struct packed {
      logic upper_gate_drive;
      logic lower_gate_drive;
      logic discharge_on;
   } bfs_drv_t;
   typedef enum logic [1:0] {
      BFS_RUN   = 2'b00,
      BFS_OV    = 2'b01,
      BFS_UV    = 2'b10
   } bfs_state_t;
endpackage

// *** bfs_timer.sv ***
// Restartable cycle counter that flags when its limit is reached
`timescale 1ns/1ns
module bfs_timer #(
   parameter int               W     = 20,
   parameter logic [W-1:0]     LIMIT = 20'h3d090
) (
   // Clock and reset
   input  wire logic           core_clk,
   input  wire logic           resetn,
   // Control
   input  wire logic           run,
   // Status
   output logic                done
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt_ff;
   logic         done_ff;
   logic         nxt_done_ff;

   // Count while run holds; clearing on drop makes it a persistence timer
   always_comb begin
      nxt_cnt_ff  = cnt_ff;
      nxt_done_ff = done_ff;
      if (!run) begin
         nxt_cnt_ff  = '0;
         nxt_done_ff = 1'b0;
      end else if (cnt_ff >= LIMIT - 1'b1) begin
         nxt_done_ff = 1'b1;
      end else begin
         nxt_cnt_ff = cnt_ff + 1'b1;
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt_ff;
         done_ff <= nxt_done_ff;
      end
   end

   assign done = done_ff;
endmodule

// *** bfs_supervisor.sv ***
// Fault supervision logic of a synchronous buck controller
// Notes on behaviour
// - Feedback above 120 percent latches upper gate off, lower gate on.
// - Feedback below 70 percent flags undervoltage and starts delay count.
// - Undervoltage persisting 1 ms latches both gate drives off.
// - Undervoltage protection stays inactive until 1.2 ms after enable rises.
// - Transition pin outside window starts masking power-good, OV and UV.
// - One cycle after masking begins, transition pin starts sinking or sourcing current.
// - Masking releases 900 us after transition pin returns inside window.
// - Bias supply lockout stops switching, non-latched, resumes on recovery.
// - Die over-temperature shuts off, non-latched.
// - After soft-start, power-good rises 1 ms after entering tight window.
// - Power-good falls 2 us after output leaves wide window.
// - Enable low holds both drives off and turns discharge on.
`include "bfs_defs.svh"
`timescale 1ns/1ns
module bfs_supervisor #(
   parameter int UV_DELAY_CYC  = `BFS_UV_DELAY_CYC,
   parameter int UV_ARM_CYC    = `BFS_UV_ARM_CYC,
   parameter int MASK_HOLD_CYC = `BFS_MASK_HOLD_CYC,
   parameter int PG_RISE_CYC   = `BFS_PG_RISE_CYC,
   parameter int PG_FALL_CYC   = `BFS_PG_FALL_CYC
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // Enable and soft-start status
   input  wire logic              enable,
   input  wire logic              soft_start_done,
   // Analog comparator results
   input  wire bfs_pkg::bfs_cmp_t cmp,
   // Modulator request for the switching drives
   input  wire bfs_pkg::bfs_drv_t pwm_req,
   // Gate driver outputs
   output bfs_pkg::bfs_drv_t      drv,
   // Status outputs
   output logic                   undervoltage_flag,
   output logic                   output_in_range_flag,
   output logic                   tran_current_on,
   output logic                   fault_masked
);
   import bfs_pkg::*;

   localparam int W = `BFS_CNT_W;
   // Safe drive: both gates off, discharge on
   localparam bfs_drv_t DRV_SAFE = bfs_drv_t'(`BFS_DRV_RESET);

   // Fault latch state
   bfs_state_t state_ff;
   bfs_state_t nxt_state_ff;

   // Mask and power-good registers
   logic       mask_ff;
   logic       nxt_mask_ff;
   logic       pg_ff;
   logic       nxt_pg_ff;

   // Registered drives and undervoltage flag
   bfs_drv_t   drv_ff;
   bfs_drv_t   nxt_drv_ff;
   logic       uv_flag_ff;
   logic       nxt_uv_flag_ff;

   // Timer controls and results
   logic       uv_armed;
   logic       uv_done;
   logic       hold_done;
   logic       pg_rise_done;
   logic       pg_fall_done;
   logic       uv_run;
   logic       hold_run;

   // Live mask, one cycle ahead of the register
   logic       mask_now;

   // Blanking after enable rises; enable low restarts it
   // A short enable pulse therefore never arms the latch
   bfs_timer #(.W(W), .LIMIT(W'(UV_ARM_CYC))) u_arm (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (enable),
      .done     (uv_armed)
   );

   // Undervoltage persistence; a masked or unarmed dip does not count
   // Any break in the dip restarts the full delay
   assign uv_run = enable && uv_armed && !mask_now && cmp.under_70;
   bfs_timer #(.W(W), .LIMIT(W'(UV_DELAY_CYC))) u_uv (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (uv_run),
      .done     (uv_done)
   );

   // Mask hold starts once the pin is back inside the window
   // A fresh excursion during the hold restarts the interval
   assign hold_run = mask_ff && !cmp.tran_out;
   bfs_timer #(.W(W), .LIMIT(W'(MASK_HOLD_CYC))) u_hold (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (hold_run),
      .done     (hold_done)
   );

   // Power-good rise qualification, only after soft-start
   // and only while enable holds
   bfs_timer #(.W(W), .LIMIT(W'(PG_RISE_CYC))) u_pgr (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (enable && soft_start_done && cmp.in_pg_rise),
      .done     (pg_rise_done)
   );

   // Power-good fall qualification; runs even while masked
   // so a step that ends outside the window drops it promptly
   bfs_timer #(.W(W), .LIMIT(W'(PG_FALL_CYC))) u_pgf (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (cmp.out_pg_fall),
      .done     (pg_fall_done)
   );

   // Masking is immediate on leaving the window, not a cycle late
   assign mask_now = cmp.tran_out || mask_ff;

   // Mask state: set wins over the hold release
   // Enable low drops the mask at once, like the other state
   always_comb begin
      nxt_mask_ff = mask_ff;
      if (!enable) begin
         nxt_mask_ff = 1'b0;
      end else if (cmp.tran_out) begin
         nxt_mask_ff = 1'b1;
      end else if (hold_done) begin
         nxt_mask_ff = 1'b0;
      end
   end

   // Fault latch; only enable low leaves a latched state
   // Overvoltage is tested first, so it wins a tie with undervoltage
   always_comb begin
      nxt_state_ff = state_ff;
      case (state_ff)
         BFS_RUN: begin
            if (enable && cmp.over_120 && !mask_now) begin
               nxt_state_ff = BFS_OV;
            end else if (enable && uv_done && !mask_now) begin
               nxt_state_ff = BFS_UV;
            end
         end
         BFS_OV, BFS_UV: begin
            if (!enable) begin
               nxt_state_ff = BFS_RUN;
            end
         end
         default: nxt_state_ff = BFS_RUN;
      endcase
   end

   // Drive selection; lockout and thermal gate drives without latching
   // They rank above a latched fault: with no bias no gate can be held on,
   // and the latch itself survives, so it drives again on recovery
   always_comb begin
      nxt_drv_ff = '0;
      if (!enable) begin
         nxt_drv_ff = DRV_SAFE;
      end else if (cmp.bias_uvlo || cmp.over_temp) begin
         nxt_drv_ff = '0;
      end else if (state_ff == BFS_OV) begin
         nxt_drv_ff.lower_gate_drive = 1'b1;
      end else if (state_ff == BFS_UV) begin
         nxt_drv_ff = '0;
      end else begin
         nxt_drv_ff.upper_gate_drive = pwm_req.upper_gate_drive;
         nxt_drv_ff.lower_gate_drive = pwm_req.lower_gate_drive;
         // Never both on: upper wins off to avoid shoot-through
         if (pwm_req.upper_gate_drive && pwm_req.lower_gate_drive) begin
            nxt_drv_ff.upper_gate_drive = 1'b0;
         end
      end
   end

   // Power-good and undervoltage flag
   // Lockout leaves power-good alone; a latched fault forces it low
   always_comb begin
      nxt_uv_flag_ff = enable && cmp.under_70;
      nxt_pg_ff      = pg_ff;
      if (!enable || state_ff != BFS_RUN || !soft_start_done) begin
         nxt_pg_ff = 1'b0;
      end else if (mask_now) begin
         nxt_pg_ff = pg_ff;  // held through a voltage step
      end else if (pg_fall_done) begin
         nxt_pg_ff = 1'b0;
      end else if (pg_rise_done) begin
         nxt_pg_ff = 1'b1;
      end
   end

   // Registers; reset leaves the same safe state as enable low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff   <= BFS_RUN;
         mask_ff    <= 1'b0;
         pg_ff      <= 1'b0;
         drv_ff     <= DRV_SAFE;
         uv_flag_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state_ff;
         mask_ff    <= nxt_mask_ff;
         pg_ff      <= nxt_pg_ff;
         drv_ff     <= nxt_drv_ff;
         uv_flag_ff <= nxt_uv_flag_ff;
      end
   end

   // Outputs
   // fault_masked is combinational, so it leads tran_current_on
   assign drv                  = drv_ff;
   assign undervoltage_flag    = uv_flag_ff;
   assign output_in_range_flag = pg_ff;
   assign tran_current_on      = mask_ff;
   assign fault_masked         = mask_now;
endmodule

// *** bfs_analog_model.sv ***
// Comparator stand-in: feedback percent to threshold flags
`timescale 1ns/1ns
module bfs_analog_model (
   // Levels set by the bench
   input  wire logic [7:0]      fb_pct,
   input  wire logic            bias_low,
   input  wire logic            hot,
   input  wire logic            tran_dev,
   // Comparator results
   output bfs_pkg::bfs_cmp_t    cmp
);
   import bfs_pkg::*;
   // Ideal thresholds, no hysteresis, so edges are exact
   always_comb begin
      cmp = '{fb_pct > 8'h78,
              fb_pct < 8'h46,
              fb_pct >= 8'h5f && fb_pct <= 8'h6e,
              fb_pct < 8'h5a || fb_pct > 8'h73,
              bias_low,
              hot,
              tran_dev};
   end
endmodule

// *** bfs_supervisor_chk.sv ***
// Port assertions for the fault supervisor
`include "bfs_defs.svh"
`timescale 1ns/1ns
module bfs_supervisor_chk #(
   parameter int MASK_HOLD_CYC = `BFS_MASK_HOLD_CYC,
   parameter int PG_FALL_CYC   = `BFS_PG_FALL_CYC
) (
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              resetn,
   // Inputs
   input wire logic              enable,
   input wire bfs_pkg::bfs_cmp_t cmp,
   // Outputs
   input wire bfs_pkg::bfs_drv_t drv,
   input wire logic              undervoltage_flag,
   input wire logic              output_in_range_flag,
   input wire logic              tran_current_on,
   input wire logic              fault_masked
);
   import bfs_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   localparam int CW = `BFS_CNT_W;
   logic [CW-1:0] quiet_cnt_ff;
   logic [CW-1:0] bad_cnt_ff;
   // Run lengths: back inside the window, and out of the wide window
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         quiet_cnt_ff <= '0;
         bad_cnt_ff   <= '0;
      end else begin
         if (!enable || cmp.tran_out) begin
            quiet_cnt_ff <= '0;
         end else if (quiet_cnt_ff != '1) begin
            quiet_cnt_ff <= quiet_cnt_ff + 1'b1;
         end
         if (!(enable && cmp.out_pg_fall && !fault_masked)) begin
            bad_cnt_ff <= '0;
         end else if (bad_cnt_ff != '1) begin
            bad_cnt_ff <= bad_cnt_ff + 1'b1;
         end
      end
   end
   // Overvoltage that is not masked
   sequence ov_hit;
      enable && cmp.over_120 && !fault_masked;
   endsequence
   // Pin left the window, then came straight back
   sequence tran_blip;
      (enable && cmp.tran_out) ##1 !cmp.tran_out;
   endsequence
   // Transition pin back inside for longer than the hold
   sequence tran_quiet;
      quiet_cnt_ff >= MASK_HOLD_CYC + 1;
   endsequence
   // Wide window left for longer than the fall delay
   sequence pg_bad;
      bad_cnt_ff >= PG_FALL_CYC + 1;
   endsequence
   chk_ov_upper_off:
   assert property (ov_hit |-> ##2 (!drv.upper_gate_drive)[*3])
      else $error("upper gate on after overvoltage");
   chk_uv_flag_set:
   assert property (enable && cmp.under_70 |=> undervoltage_flag)
      else $error("undervoltage flag missing");
   chk_mask_now:
   assert property (tran_blip |-> fault_masked)
      else $error("faults not masked");
   chk_tran_current:
   assert property (enable && cmp.tran_out |=> tran_current_on)
      else $error("transition current not on");
   chk_mask_release:
   assert property (tran_quiet |-> !tran_current_on)
      else $error("mask held too long");
   chk_bias_lockout:
   assert property (cmp.bias_uvlo |=> !drv.upper_gate_drive
                    && !drv.lower_gate_drive)
      else $error("drives on in bias lockout");
   chk_hot_shutdown:
   assert property (cmp.over_temp |=> !drv.upper_gate_drive
                    && !drv.lower_gate_drive)
      else $error("drives on when hot");
   chk_pg_fall_late:
   assert property (pg_bad |-> !output_in_range_flag)
      else $error("power good not dropped");
   chk_enable_off:
   assert property (!enable |=> drv == 3'h1)
      else $error("drives wrong with enable low");
endmodule
bind bfs_supervisor bfs_supervisor_chk #(
   .MASK_HOLD_CYC(MASK_HOLD_CYC), .PG_FALL_CYC(PG_FALL_CYC)
) bfs_supervisor_chk_i (
   .core_clk(core_clk), .resetn(resetn), .enable(enable), .cmp(cmp),
   .drv(drv), .undervoltage_flag(undervoltage_flag),
   .output_in_range_flag(output_in_range_flag),
   .tran_current_on(tran_current_on), .fault_masked(fault_masked));

// *** bfs_supervisor_test.sv ***
// Self-checking bench for the fault supervisor
`timescale 1ns/1ns
module bfs_supervisor_test;
   import bfs_pkg::*;
   logic       core_clk, resetn, enable, soft_start_done;
   logic       bias_low, hot, tran_dev, uv_flag, pg, tran_on, masked;
   logic [7:0] fb_pct;
   bfs_cmp_t   cmp;
   bfs_drv_t   pwm_req, drv;
   int         fail_count, checked, cycles;
   // Rows: bias low, hot, expected upper and lower drive
   logic [3:0] rows [5] = '{4'h2, 4'h8, 4'h2, 4'h4, 4'h2};
   bfs_analog_model bfs_analog_model_i (.fb_pct(fb_pct),
      .bias_low(bias_low), .hot(hot), .tran_dev(tran_dev), .cmp(cmp));
   bfs_supervisor #(.UV_DELAY_CYC(10), .UV_ARM_CYC(12), .MASK_HOLD_CYC(9),
      .PG_RISE_CYC(10), .PG_FALL_CYC(4)) bfs_supervisor_i (
      .core_clk(core_clk), .resetn(resetn), .enable(enable),
      .soft_start_done(soft_start_done), .cmp(cmp), .pwm_req(pwm_req),
      .drv(drv), .undervoltage_flag(uv_flag), .output_in_range_flag(pg),
      .tran_current_on(tran_on), .fault_masked(masked));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Hang guard, well above the under 200 cycles used
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // Wait edges, then settle so outputs are stable
   task automatic go(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic cmp_v(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {resetn, enable, soft_start_done, bias_low, hot, tran_dev} = 6'h0;
      {fail_count, checked, cycles} = 0;
      fb_pct = 8'h64;
      pwm_req = 3'h4;
      go(3);
      cmp_v(drv, 3'h1);
      @(posedge core_clk) {resetn, enable, soft_start_done} <= 3'h7;
      go(5);
      cmp_v({2'h0, pg}, 3'h0);
      go(30);
      cmp_v({2'h0, pg}, 3'h1);
      // Non-latched lockout and thermal rows
      foreach (rows[i]) begin
         @(posedge core_clk) {bias_low, hot} <= rows[i][3:2];
         go(3);
         cmp_v({1'h0, drv[2:1]}, {1'h0, rows[i][1:0]});
      end
      $display("test rows finished");
      @(posedge core_clk) fb_pct <= 8'h50;
      go(2);
      cmp_v({2'h0, pg}, 3'h1);
      go(6);
      cmp_v({2'h0, pg}, 3'h0);
      @(posedge core_clk) {fb_pct, tran_dev} <= {8'h64, 1'h1};
      go(2);
      cmp_v({1'h0, tran_on, masked}, 3'h3);
      @(posedge core_clk) fb_pct <= 8'h7d;
      go(3);
      cmp_v({1'h0, drv[2:1]}, 3'h2);
      @(posedge core_clk) {fb_pct, tran_dev} <= {8'h64, 1'h0};
      go(4);
      cmp_v({2'h0, tran_on}, 3'h1);
      go(14);
      cmp_v({2'h0, tran_on}, 3'h0);
      $display("test mask finished");
      @(posedge core_clk) fb_pct <= 8'h3c;
      go(16);
      cmp_v({uv_flag, drv[2:1]}, 3'h4);
      @(posedge core_clk) fb_pct <= 8'h64;
      go(3);
      cmp_v({1'h0, drv[2:1]}, 3'h0);
      @(posedge core_clk) enable <= 1'h0;
      go(2);
      cmp_v(drv, 3'h1);
      @(posedge core_clk) {enable, fb_pct} <= {1'h1, 8'h3c};
      go(9);
      cmp_v({1'h0, drv[2:1]}, 3'h2);
      @(posedge core_clk) fb_pct <= 8'h7d;
      @(posedge core_clk) fb_pct <= 8'h64;
      go(3);
      cmp_v({1'h0, drv[2:1]}, 3'h1);
      go(5);
      cmp_v({1'h0, drv[2:1]}, 3'h1);
      @(posedge core_clk) enable <= 1'h0;
      go(2);
      @(posedge core_clk) enable <= 1'h1;
      go(3);
      cmp_v({1'h0, drv[2:1]}, 3'h2);
      @(posedge core_clk) soft_start_done <= 1'h0;
      go(14);
      cmp_v({2'h0, pg}, 3'h0);
      @(posedge core_clk) soft_start_done <= 1'h1;
      go(12);
      cmp_v({2'h0, pg}, 3'h1);
      $display("test faults finished");
      tally_and_finish();
   end
endmodule
